//--- hdl/cad_exec.sv
/*
  execution datapath: byte and word arithmetic, logic, multiply and
  indirect goto/call, with status flags and cycle timing.
  assumes: operands stable while op_valid_i is high.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - add registers, optional carry, five flags, one cycle
// - subtract register or constant, five flags, one cycle
// - subtract with carry also subtracts carry flag
// - word add/subtract constant, five flags, two cycles
// - and/or/xor store result, z n v only
// - bit clear ands complement mask, bit set ors
// - test ands register with itself, z n v
// - multiply writes product pair, z c, two cycles
// - fractional multiply shifts product left one bit
// - indirect goto loads pointer, no flags, two cycles
// - indirect call saves return, loads pointer, four cycles
module cad_exec (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             op_valid_i,
  input  wire cad_pkg::cad_op_e op_i,
  input  wire logic [7:0]       rd_i,
  input  wire logic [7:0]       src_reg_i,
  input  wire logic [7:0]       imm_i,
  input  wire logic [15:0]      pair_i,
  input  wire logic [15:0]      ptr_i,
  input  wire logic [15:0]      ret_addr_i,
  input  wire logic [7:0]       sreg_i,
  output logic                  ready_o,
  output logic                  done_o,
  output logic                  rd_wr_o,
  output logic [7:0]            rd_data_o,
  output logic                  pair_wr_o,
  output logic [15:0]           pair_data_o,
  output logic                  product_pair_wr_o,
  output logic [15:0]           product_pair_o,
  output logic                  sreg_wr_o,
  output logic [7:0]            sreg_o,
  output logic                  pc_load_o,
  output logic [15:0]           pc_o,
  output logic                  push_o,
  output logic [7:0]            push_data_o
);
  // ==========================================================
  // decode helpers
  function automatic logic [2:0] cycles_of(input cad_pkg::cad_op_e o);
    case (o)
      cad_pkg::OP_WORD_SUM_IMM,
      cad_pkg::OP_WORD_MINUS_IMM:  cycles_of = cad_pkg::CYC_WORD;
      cad_pkg::OP_INDIRECT_GOTO:   cycles_of = cad_pkg::CYC_GOTO;
      cad_pkg::OP_INDIRECT_SUBR:   cycles_of = cad_pkg::CYC_SUBR;
      default:
        cycles_of = (o >= cad_pkg::OP_PRODUCT) ? cad_pkg::CYC_MUL
                                               : cad_pkg::CYC_ALU;
    endcase
  endfunction

  // true for the operand b taken from the constant
  function automatic logic uses_imm(input cad_pkg::cad_op_e o);
    uses_imm = (o == cad_pkg::OP_MINUS_IMM) ||
               (o == cad_pkg::OP_MINUS_CARRY_IMM) ||
               (o == cad_pkg::OP_CONJ_IMM) ||
               (o == cad_pkg::OP_DISJ_IMM) ||
               (o == cad_pkg::OP_BITSET) ||
               (o == cad_pkg::OP_BITCLEAR);
  endfunction

  // ==========================================================
  // operand selection and group decode
  wire logic       take    = op_valid_i & ready_o;
  wire logic [7:0] opb     = uses_imm(op_i) ? imm_i : src_reg_i;
  wire logic       is_add  = (op_i <= cad_pkg::OP_SUM_CARRY);
  wire logic       is_sub  = (op_i >= cad_pkg::OP_MINUS) &&
                             (op_i <= cad_pkg::OP_MINUS_CARRY_IMM);
  wire logic       is_word = (op_i == cad_pkg::OP_WORD_SUM_IMM) ||
                             (op_i == cad_pkg::OP_WORD_MINUS_IMM);
  wire logic       is_log  = (op_i >= cad_pkg::OP_CONJ) &&
                             (op_i <= cad_pkg::OP_SELF_TEST);
  wire logic       is_mul  = (op_i >= cad_pkg::OP_PRODUCT) &&
                             (op_i <= cad_pkg::OP_FRAC_MIXED_PRODUCT);
  // carry-in only for the with-carry forms
  wire logic       use_c   = (op_i == cad_pkg::OP_SUM_CARRY) |
                             (op_i == cad_pkg::OP_MINUS_CARRY) |
                             (op_i == cad_pkg::OP_MINUS_CARRY_IMM);
  wire logic       ci      = use_c & sreg_i[cad_pkg::FLG_C];

  // ==========================================================
  // byte add and subtract with carry and half carry
  wire logic [8:0] sum9  = {1'b0, rd_i} + {1'b0, opb} + {8'h00, ci};
  wire logic [4:0] sum5  = {1'b0, rd_i[3:0]} + {1'b0, opb[3:0]} + {4'h0, ci};
  wire logic [8:0] dif9  = {1'b0, rd_i} - {1'b0, opb} - {8'h00, ci};
  wire logic [4:0] dif5  = {1'b0, rd_i[3:0]} - {1'b0, opb[3:0]} - {4'h0, ci};
  wire logic [7:0] ar_res = is_add ? sum9[7:0] : dif9[7:0];
  wire logic       ar_c   = is_add ? sum9[8] : dif9[8];
  wire logic       ar_h   = is_add ? sum5[4] : dif5[4];
  // overflow: add of like signs, subtract of unlike signs
  wire logic       ar_v   = is_add
    ? (rd_i[7] == opb[7]) && (ar_res[7] != rd_i[7])
    : (rd_i[7] != opb[7]) && (ar_res[7] != rd_i[7]);

  // ==========================================================
  // logic group
  logic [7:0] lg_res;
  always_comb
  begin
    case (op_i)
      cad_pkg::OP_CONJ,
      cad_pkg::OP_CONJ_IMM:  lg_res = rd_i & opb;
      cad_pkg::OP_DISJ,
      cad_pkg::OP_DISJ_IMM,
      cad_pkg::OP_BITSET:    lg_res = rd_i | opb;
      cad_pkg::OP_XOR_REG:   lg_res = rd_i ^ opb;
      cad_pkg::OP_BITCLEAR:  lg_res = rd_i & (8'hFF - opb);
      default:               lg_res = rd_i & rd_i;
    endcase
  end

  // ==========================================================
  // word add and subtract of a constant on the register pair
  wire logic        w_add  = (op_i == cad_pkg::OP_WORD_SUM_IMM);
  wire logic [15:0] w_res  = w_add ? pair_i + {8'h00, imm_i}
                                   : pair_i - {8'h00, imm_i};
  wire logic        w_v    = w_add ? (~pair_i[15] & w_res[15])
                                   : (pair_i[15] & ~w_res[15]);
  wire logic        w_c    = w_add ? (pair_i[15] & ~w_res[15])
                                   : (~pair_i[15] & w_res[15]);

  // ==========================================================
  // multiplier
  cad_mul_if mif ();
  assign mif.a     = rd_i;
  assign mif.b     = src_reg_i;
  assign mif.sgn_a = is_mul && (op_i != cad_pkg::OP_PRODUCT) &&
                     (op_i != cad_pkg::OP_FRAC_PRODUCT);
  assign mif.sgn_b = (op_i == cad_pkg::OP_SIGNED_PRODUCT) ||
                     (op_i == cad_pkg::OP_FRAC_SIGNED_PRODUCT);
  assign mif.frac  = (op_i >= cad_pkg::OP_FRAC_PRODUCT);
  cad_mul u_mul (
    .m (mif)
  );

  // ==========================================================
  // new flag values and the mask of flags that may change
  logic [7:0] fl_new;
  logic [7:0] fl_msk;
  always_comb
  begin
    fl_new = 8'h00;
    fl_msk = cad_pkg::MSK_NONE;
    if (is_add || is_sub)
    begin
      fl_new[cad_pkg::FLG_C] = ar_c;
      fl_new[cad_pkg::FLG_Z] = (ar_res == 8'h00);
      fl_new[cad_pkg::FLG_N] = ar_res[7];
      fl_new[cad_pkg::FLG_V] = ar_v;
      fl_new[cad_pkg::FLG_H] = ar_h;
      fl_msk = cad_pkg::MSK_ARITH;
    end
    else if (is_word)
    begin
      fl_new[cad_pkg::FLG_C] = w_c;
      fl_new[cad_pkg::FLG_Z] = (w_res == 16'h0000);
      fl_new[cad_pkg::FLG_N] = w_res[15];
      fl_new[cad_pkg::FLG_V] = w_v;
      fl_new[cad_pkg::FLG_S] = w_res[15] ^ w_v;
      fl_msk = cad_pkg::MSK_WORD;
    end
    else if (is_log)
    begin
      fl_new[cad_pkg::FLG_Z] = (lg_res == 8'h00);
      fl_new[cad_pkg::FLG_N] = lg_res[7];
      fl_msk = cad_pkg::MSK_LOGIC;
    end
    else if (is_mul)
    begin
      fl_new[cad_pkg::FLG_C] = mif.carry;
      fl_new[cad_pkg::FLG_Z] = mif.zero;
      fl_msk = cad_pkg::MSK_MUL;
    end
  end

  // unlisted flags keep their incoming value
  wire logic [7:0] sreg_nxt = (sreg_i & ~fl_msk) | (fl_new & fl_msk);

  // ==========================================================
  // control: state, cycle counter and registered results
  cad_pkg::cad_state_e state_r;
  logic [2:0]  cnt_r;        // cycles still to run
  logic        subr_r;       // running an indirect call
  logic        rd_wr_r;      // pending byte write
  logic        pair_wr_r;    // pending pair write
  logic        prod_wr_r;    // pending product write
  logic        sreg_wr_r;    // pending status write
  logic        pcl_r;        // pending program counter load
  logic [15:0] ret_r;        // return address to push
  logic        done_r;       // one-cycle completion pulse

  wire logic [2:0] ncyc   = cycles_of(op_i);
  wire logic       finish = (state_r == cad_pkg::ST_RUN) && (cnt_r == 3'h1);
  wire logic       fire1  = take && (ncyc == cad_pkg::CYC_ALU);

  assign ready_o           = (state_r == cad_pkg::ST_IDLE);
  assign done_o            = done_r;
  assign rd_wr_o           = done_r & rd_wr_r;
  assign pair_wr_o         = done_r & pair_wr_r;
  assign product_pair_wr_o = done_r & prod_wr_r;
  assign sreg_wr_o         = done_r & sreg_wr_r;
  assign pc_load_o         = done_r & pcl_r;

  // state and counter
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= cad_pkg::ST_IDLE;
      cnt_r   <= 3'h0;
      done_r  <= 1'b0;
    end
    else
    begin
      done_r <= fire1 | finish;
      case (state_r)
        cad_pkg::ST_IDLE:
          if (take && !fire1)
          begin
            state_r <= cad_pkg::ST_RUN;
            cnt_r   <= ncyc - 3'h1;
          end
        cad_pkg::ST_RUN:
        begin
          cnt_r <= cnt_r - 3'h1;
          if (finish)
            state_r <= cad_pkg::ST_IDLE;
        end
        default: state_r <= cad_pkg::ST_IDLE;
      endcase
    end
  end

  // results are captured when the operation is taken
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_wr_r        <= 1'b0;
      pair_wr_r      <= 1'b0;
      prod_wr_r      <= 1'b0;
      sreg_wr_r      <= 1'b0;
      pcl_r          <= 1'b0;
      subr_r         <= 1'b0;
      rd_data_o      <= cad_pkg::RST_BYTE;
      pair_data_o    <= cad_pkg::RST_WORD;
      product_pair_o <= cad_pkg::RST_WORD;
      sreg_o         <= cad_pkg::RST_BYTE;
      pc_o           <= cad_pkg::RST_WORD;
      ret_r          <= cad_pkg::RST_WORD;
    end
    else if (take)
    begin
      rd_wr_r        <= is_add | is_sub | is_log;
      pair_wr_r      <= is_word;
      prod_wr_r      <= is_mul;
      sreg_wr_r      <= (fl_msk != cad_pkg::MSK_NONE);
      pcl_r          <= (op_i == cad_pkg::OP_INDIRECT_GOTO) ||
                        (op_i == cad_pkg::OP_INDIRECT_SUBR);
      subr_r         <= (op_i == cad_pkg::OP_INDIRECT_SUBR);
      rd_data_o      <= is_log ? lg_res : ar_res;
      pair_data_o    <= w_res;
      product_pair_o <= mif.prod;
      sreg_o         <= sreg_nxt;
      pc_o           <= ptr_i;
      ret_r          <= ret_addr_i;
    end
  end

  // return address pushed low byte then high byte before the load
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      push_o      <= 1'b0;
      push_data_o <= cad_pkg::RST_BYTE;
    end
    else
    begin
      push_o      <= (state_r == cad_pkg::ST_RUN) && subr_r &&
                     (cnt_r >= 3'h2);
      push_data_o <= (cnt_r == 3'h3) ? ret_r[7:0] : ret_r[15:8];
    end
  end
endmodule
`default_nettype wire

//--- hdl/cad_pkg.sv
/*
  shared constants and types of the core execution datapath: operation
  codes, status flag positions, cycle counts and the control states.
  assumes: compiled before every other file of the block.
*/
`default_nettype none
package cad_pkg;

  // ==========================================================
  // status register flag positions
  localparam int FLG_C = 0;  // carry
  localparam int FLG_Z = 1;  // zero
  localparam int FLG_N = 2;  // negative
  localparam int FLG_V = 3;  // two's complement overflow
  localparam int FLG_S = 4;  // sign, n xor v
  localparam int FLG_H = 5;  // half carry

  // flags touched by each operation group
  localparam logic [7:0] MSK_ARITH = 8'h2F;  // h v n z c
  localparam logic [7:0] MSK_WORD  = 8'h1F;  // s v n z c
  localparam logic [7:0] MSK_LOGIC = 8'h0E;  // v n z
  localparam logic [7:0] MSK_MUL   = 8'h03;  // z c
  localparam logic [7:0] MSK_NONE  = 8'h00;

  // ==========================================================
  // cycle counts per operation group
  localparam logic [2:0] CYC_ALU  = 3'h1;
  localparam logic [2:0] CYC_WORD = 3'h2;
  localparam logic [2:0] CYC_MUL  = 3'h2;
  localparam logic [2:0] CYC_GOTO = 3'h2;
  localparam logic [2:0] CYC_SUBR = 3'h4;

  // reset values of the result registers
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ==========================================================
  // operation codes presented by the instruction decoder
  typedef enum logic [4:0] {
    OP_SUM            = 5'h00,
    OP_SUM_CARRY      = 5'h01,
    OP_MINUS          = 5'h02,
    OP_MINUS_IMM      = 5'h03,
    OP_MINUS_CARRY    = 5'h04,
    OP_MINUS_CARRY_IMM= 5'h05,
    OP_WORD_SUM_IMM   = 5'h06,
    OP_WORD_MINUS_IMM = 5'h07,
    OP_CONJ           = 5'h08,
    OP_CONJ_IMM       = 5'h09,
    OP_DISJ           = 5'h0A,
    OP_DISJ_IMM       = 5'h0B,
    OP_XOR_REG        = 5'h0C,
    OP_BITSET         = 5'h0D,
    OP_BITCLEAR       = 5'h0E,
    OP_SELF_TEST      = 5'h0F,
    OP_PRODUCT        = 5'h10,
    OP_SIGNED_PRODUCT = 5'h11,
    OP_MIXED_PRODUCT  = 5'h12,
    OP_FRAC_PRODUCT   = 5'h13,
    OP_FRAC_SIGNED_PRODUCT = 5'h14,
    OP_FRAC_MIXED_PRODUCT  = 5'h15,
    OP_INDIRECT_GOTO  = 5'h16,
    OP_INDIRECT_SUBR  = 5'h17
  } cad_op_e;

  // control states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } cad_state_e;

endpackage
`default_nettype wire

//--- hdl/cad_mul_if.sv
/*
  carrier between the datapath and its multiplier: operands, mode and
  the shaped product with its flags.
  assumes: purely combinational use inside one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface cad_mul_if;
  logic [7:0]  a;       // first operand
  logic [7:0]  b;       // second operand
  logic        sgn_a;   // first operand is signed
  logic        sgn_b;   // second operand is signed
  logic        frac;    // fractional, shift left by one
  logic [15:0] prod;    // product for the product pair
  logic        carry;   // bit 15 before the shift
  logic        zero;    // product is zero

  // ==========================================================
  modport user (output a, b, sgn_a, sgn_b, frac,
                input  prod, carry, zero);
  modport unit (input  a, b, sgn_a, sgn_b, frac,
                output prod, carry, zero);
endinterface
`default_nettype wire

//--- hdl/cad_mul.sv
/*
  8 by 8 multiplier for the unsigned, signed, mixed and fractional
  forms. combinational; the caller registers the result.
  assumes: operands held stable for the whole operation.
*/
`timescale 1ns/1ps
`default_nettype none
module cad_mul (
  cad_mul_if.unit m
);
  // ==========================================================
  // sign extension picks the operand interpretation
  wire logic signed [8:0]  ext_a = {m.sgn_a & m.a[7], m.a};
  wire logic signed [8:0]  ext_b = {m.sgn_b & m.b[7], m.b};
  wire logic signed [17:0] full  = ext_a * ext_b;
  wire logic [15:0]        raw   = full[15:0];

  // fractional forms shift left; carry is taken before the shift
  assign m.prod  = m.frac ? {raw[14:0], 1'b0} : raw;
  assign m.carry = raw[15];
  assign m.zero  = (m.prod == 16'h0000);
endmodule
`default_nettype wire

//--- test/cad_rf_model.sv
/*
  partner model of the register file side: keeps what the datapath
  pushes on the stack and the last program counter it loaded.
  assumes: strobes are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cad_rf_model (
  input  wire logic        clk_i,        // core clock
  input  wire logic        rstn_i,       // reset, low active
  input  wire logic        push_i,       // one byte pushed
  input  wire logic [7:0]  push_data_i,  // pushed byte
  input  wire logic        pc_load_i,    // counter load strobe
  input  wire logic [15:0] pc_i,         // new counter
  output logic      [15:0] stack_o,      // last two bytes, low first
  output logic      [15:0] pc_o          // last loaded counter
);
  // ==========================================================
  // stack capture: low byte then high byte shift in from the top
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stack_o <= 16'h0000;
      pc_o    <= 16'h0000;
    end
    else
    begin
      if (push_i)  // return address byte
        stack_o <= {push_data_i, stack_o[15:8]};
      if (pc_load_i)  // jump target taken
        pc_o <= pc_i;
    end
  end
endmodule
`default_nettype wire

//--- test/cad_exec_chk.sv
/*
  concurrent checks on the datapath ports: timing of completion,
  strobes, flag masking and the goto and call sequences.
  assumes: one clock domain, bound to every cad_exec instance.
*/
`timescale 1ns/1ps
`default_nettype none
module cad_exec_chk (
  input wire logic             clk_i,
  input wire logic             rstn_i,
  input wire logic             op_valid_i,
  input wire cad_pkg::cad_op_e op_i,
  input wire logic [7:0]       rd_i,
  input wire logic [7:0]       src_reg_i,
  input wire logic [7:0]       imm_i,
  input wire logic [15:0]      ptr_i,
  input wire logic [7:0]       sreg_i,
  input wire logic             ready_o,
  input wire logic             done_o,
  input wire logic             rd_wr_o,
  input wire logic [7:0]       rd_data_o,
  input wire logic             pair_wr_o,
  input wire logic             product_pair_wr_o,
  input wire logic [15:0]      product_pair_o,
  input wire logic             sreg_wr_o,
  input wire logic [7:0]       sreg_o,
  input wire logic             pc_load_o,
  input wire logic [15:0]      pc_o,
  input wire logic             push_o
);
  // ==========================================================
  // request taken on this edge
  wire logic take;
  assign take = op_valid_i & ready_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ==========================================================
  a_sum_value: assert property (take && op_i == cad_pkg::OP_SUM |=>
    done_o && rd_wr_o && rd_data_o == 8'($past(rd_i) + $past(src_reg_i)))
    else $error("add result wrong");
  a_clear_mask: assert property (take &&
    op_i == cad_pkg::OP_BITCLEAR |=>
    rd_data_o == ($past(rd_i) & ~$past(imm_i)))
    else $error("bit clear result wrong");
  a_logic_flags: assert property (take &&
    op_i == cad_pkg::OP_XOR_REG |=>
    !sreg_o[cad_pkg::FLG_V] && ((sreg_o & ~cad_pkg::MSK_LOGIC)
    == ($past(sreg_i) & ~cad_pkg::MSK_LOGIC)))
    else $error("logic flags wrong");
  a_word_time: assert property (take && op_i inside
    {cad_pkg::OP_WORD_SUM_IMM, cad_pkg::OP_WORD_MINUS_IMM}
    |=> !done_o ##1 (done_o && pair_wr_o && sreg_wr_o))
    else $error("word op timing wrong");
  a_mul_time: assert property (take && op_i >= cad_pkg::OP_PRODUCT
    && op_i <= cad_pkg::OP_FRAC_MIXED_PRODUCT
    |=> !ready_o ##1 (done_o && product_pair_wr_o && !rd_wr_o))
    else $error("multiply timing wrong");
  a_frac_shift: assert property (take &&
    op_i >= cad_pkg::OP_FRAC_PRODUCT
    && op_i <= cad_pkg::OP_FRAC_MIXED_PRODUCT |-> ##2 !product_pair_o[0])
    else $error("fractional product not shifted");
  a_goto_load: assert property (take &&
    op_i == cad_pkg::OP_INDIRECT_GOTO
    |-> ##2 (done_o && pc_load_o && !sreg_wr_o && pc_o == $past(ptr_i, 2)))
    else $error("goto wrong");
  a_call_seq: assert property (take &&
    op_i == cad_pkg::OP_INDIRECT_SUBR
    |-> ##2 push_o ##1 push_o ##1 (done_o && pc_load_o && !sreg_wr_o))
    else $error("call sequence wrong");
  a_done_ready: assert property (done_o |-> ready_o)
    else $error("not ready at completion");
  a_strobe_done: assert property ($rose(sreg_wr_o) || rd_wr_o
    |-> done_o)
    else $error("write strobe without completion");
endmodule
bind cad_exec cad_exec_chk u_cad_exec_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .op_valid_i(op_valid_i), .op_i(op_i), .rd_i(rd_i),
  .src_reg_i(src_reg_i), .imm_i(imm_i), .ptr_i(ptr_i), .sreg_i(sreg_i),
  .ready_o(ready_o), .done_o(done_o), .rd_wr_o(rd_wr_o),
  .rd_data_o(rd_data_o), .pair_wr_o(pair_wr_o),
  .product_pair_wr_o(product_pair_wr_o), .product_pair_o(product_pair_o),
  .sreg_wr_o(sreg_wr_o), .sreg_o(sreg_o), .pc_load_o(pc_load_o),
  .pc_o(pc_o), .push_o(push_o));
`default_nettype wire

//--- test/cad_exec_bench.sv
/*
  bench of the execution datapath: each operation is issued and its
  result, flags and cycle count compared.
  assumes: package, design, partner model and checker compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module cad_exec_bench;
  // ==========================================================
  // stimulus and observed signals
  logic clk_i = 1'b0;  // core clock, 10 ns
  logic rstn_i = 1'b0;  // reset, low active
  logic op_valid_i = 1'b0;  // request valid
  cad_pkg::cad_op_e op_i = cad_pkg::OP_SUM;  // operation code
  logic [7:0] rd_i = 8'h00, src_reg_i = 8'h00, imm_i = 8'h00;
  logic [7:0] sreg_i = 8'h00;  // incoming status
  logic [15:0] pair_i = 16'h0000, ptr_i = 16'h0000, ret_addr_i = 16'h0000;
  logic ready_o, done_o, rd_wr_o, pair_wr_o, product_pair_wr_o;
  logic sreg_wr_o, pc_load_o, push_o;
  logic [7:0] rd_data_o, sreg_o, push_data_o;
  logic [15:0] pair_data_o, product_pair_o, pc_o, stack_w, pc_seen;
  int errors = 0;  // mismatches
  int compares = 0;  // comparisons made

  always #5 clk_i = ~clk_i;  // 100 MHz

  cad_exec u_cad_exec (.clk_i(clk_i), .rstn_i(rstn_i),
    .op_valid_i(op_valid_i), .op_i(op_i), .rd_i(rd_i),
    .src_reg_i(src_reg_i), .imm_i(imm_i), .pair_i(pair_i), .ptr_i(ptr_i),
    .ret_addr_i(ret_addr_i), .sreg_i(sreg_i), .ready_o(ready_o),
    .done_o(done_o), .rd_wr_o(rd_wr_o), .rd_data_o(rd_data_o),
    .pair_wr_o(pair_wr_o), .pair_data_o(pair_data_o),
    .product_pair_wr_o(product_pair_wr_o), .product_pair_o(product_pair_o),
    .sreg_wr_o(sreg_wr_o), .sreg_o(sreg_o), .pc_load_o(pc_load_o),
    .pc_o(pc_o), .push_o(push_o), .push_data_o(push_data_o));
  cad_rf_model u_cad_rf_model (.clk_i(clk_i), .rstn_i(rstn_i),
    .push_i(push_o), .push_data_i(push_data_o), .pc_load_i(pc_load_o),
    .pc_i(pc_o), .stack_o(stack_w), .pc_o(pc_seen));

  // ==========================================================
  // compare tasks and closing
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // one operation: reference result, drive, wait, compare
  task automatic exec(input cad_pkg::cad_op_e op, input logic [7:0] a, b,
                      k, s, input logic [15:0] w = 16'h0000);
    logic [8:0] r9;
    logic [4:0] h5;
    logic [16:0] r17;
    logic [15:0] sa, sb, res;
    logic [7:0] f, m, bb;
    logic ci;
    int n, cyc, grp;
    f = 8'h00; m = cad_pkg::MSK_ARITH; cyc = 1; grp = 0; res = 16'h0000;
    bb = (op inside {cad_pkg::OP_MINUS_IMM, cad_pkg::OP_MINUS_CARRY_IMM,
      cad_pkg::OP_CONJ_IMM, cad_pkg::OP_DISJ_IMM, cad_pkg::OP_BITSET}) ? k : b;
    ci = s[cad_pkg::FLG_C] & (op inside {cad_pkg::OP_SUM_CARRY,
      cad_pkg::OP_MINUS_CARRY, cad_pkg::OP_MINUS_CARRY_IMM});
    case (op)
      cad_pkg::OP_SUM, cad_pkg::OP_SUM_CARRY:
      begin
        r9 = a + b + ci;
        h5 = a[3:0] + b[3:0] + ci;
        f[cad_pkg::FLG_V] = (a[7] == b[7]) && (r9[7] != a[7]);
      end
      cad_pkg::OP_MINUS, cad_pkg::OP_MINUS_IMM, cad_pkg::OP_MINUS_CARRY,
      cad_pkg::OP_MINUS_CARRY_IMM:
      begin
        r9 = {1'b0, a} - {1'b0, bb} - ci;
        h5 = {1'b0, a[3:0]} - {1'b0, bb[3:0]} - ci;
        f[cad_pkg::FLG_V] = (a[7] != bb[7]) && (r9[7] != a[7]);
      end
      cad_pkg::OP_CONJ, cad_pkg::OP_CONJ_IMM, cad_pkg::OP_SELF_TEST,
      cad_pkg::OP_DISJ, cad_pkg::OP_DISJ_IMM, cad_pkg::OP_BITSET,
      cad_pkg::OP_XOR_REG, cad_pkg::OP_BITCLEAR:
      begin
        m = cad_pkg::MSK_LOGIC;
        case (op)
          cad_pkg::OP_SELF_TEST: res = {8'h00, a};
          cad_pkg::OP_XOR_REG:   res = {8'h00, a ^ b};
          cad_pkg::OP_BITCLEAR:  res = {8'h00, a & ~k};
          cad_pkg::OP_CONJ, cad_pkg::OP_CONJ_IMM: res = {8'h00, a & bb};
          default:               res = {8'h00, a | bb};
        endcase
      end
      cad_pkg::OP_WORD_SUM_IMM, cad_pkg::OP_WORD_MINUS_IMM:
      begin
        m = cad_pkg::MSK_WORD; cyc = 2; grp = 1;
        r17 = (op == cad_pkg::OP_WORD_SUM_IMM) ? w + k : w - k;
        res = r17[15:0];
        f[cad_pkg::FLG_C] = r17[16];
        f[cad_pkg::FLG_V] = (op == cad_pkg::OP_WORD_SUM_IMM) ?
          (!w[15] && res[15]) : (w[15] && !res[15]);
        f[cad_pkg::FLG_N] = res[15];
        f[cad_pkg::FLG_Z] = (res == 16'h0000);
        f[cad_pkg::FLG_S] = res[15] ^ f[cad_pkg::FLG_V];
      end
      cad_pkg::OP_INDIRECT_GOTO, cad_pkg::OP_INDIRECT_SUBR:
      begin
        m = cad_pkg::MSK_NONE; grp = 3;
        cyc = (op == cad_pkg::OP_INDIRECT_GOTO) ? 2 : 4;
      end
      default:
      begin
        m = cad_pkg::MSK_MUL; cyc = 2; grp = 2;
        sa = (op inside {cad_pkg::OP_PRODUCT, cad_pkg::OP_FRAC_PRODUCT}) ?
          {8'h00, a} : {{8{a[7]}}, a};
        sb = (op inside {cad_pkg::OP_SIGNED_PRODUCT,
          cad_pkg::OP_FRAC_SIGNED_PRODUCT}) ? {{8{b[7]}}, b} : {8'h00, b};
        res = sa * sb;
        f[cad_pkg::FLG_C] = res[15];
        if (op >= cad_pkg::OP_FRAC_PRODUCT)
          res = res << 1;
        f[cad_pkg::FLG_Z] = (res == 16'h0000);
      end
    endcase
    if (m == cad_pkg::MSK_ARITH)
    begin
      res = {8'h00, r9[7:0]};
      f[cad_pkg::FLG_C] = r9[8];
      f[cad_pkg::FLG_H] = h5[4];
    end
    if (grp == 0)
    begin
      f[cad_pkg::FLG_Z] = (res[7:0] == 8'h00);
      f[cad_pkg::FLG_N] = res[7];
    end
    @(negedge clk_i);
    op_valid_i = 1'b1; op_i = op; rd_i = a; src_reg_i = b; imm_i = k;
    sreg_i = s; pair_i = w; ptr_i = w; ret_addr_i = ~w;
    @(posedge clk_i);
    @(negedge clk_i);
    op_valid_i = 1'b0;
    n = 1;
    while (done_o !== 1'b1 && n < 8)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_val(16'(n), 16'(cyc));
    chk_val(16'(sreg_wr_o), 16'(grp != 3));
    if (grp != 3)
      chk_val(16'(sreg_o), 16'((s & ~m) | (f & m)));
    case (grp)
      0: chk_val({8'h00, rd_data_o}, res);
      1: chk_val(pair_data_o, res);
      2: chk_val(product_pair_o, res);
      default: chk_val(pc_o, w);
    endcase
    if (op == cad_pkg::OP_INDIRECT_SUBR)
      chk_val(stack_w, ~w);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_add;
    exec(cad_pkg::OP_SUM, 8'h0F, 8'h01, 8'h00, 8'hF0);
    exec(cad_pkg::OP_SUM_CARRY, 8'h7F, 8'h00, 8'h00, 8'h01);
    exec(cad_pkg::OP_SUM, 8'h80, 8'h80, 8'h00, 8'h00);
  endtask
  task automatic t_sub;
    cad_pkg::cad_op_e ops[4] = '{cad_pkg::OP_MINUS, cad_pkg::OP_MINUS_IMM,
      cad_pkg::OP_MINUS_CARRY, cad_pkg::OP_MINUS_CARRY_IMM};
    foreach (ops[i])
      exec(ops[i], 8'h10, 8'h01, 8'h20, 8'hFF);
  endtask
  task automatic t_logic;
    for (int i = 8; i < 16; i++)
      exec(cad_pkg::cad_op_e'(i), 8'hA5, 8'h5A,
           8'h0F, 8'hFF);
  endtask
  task automatic t_word;
    exec(cad_pkg::OP_WORD_SUM_IMM, 8'h00, 8'h00, 8'h01, 8'h20,
         16'hFFFF);
    exec(cad_pkg::OP_WORD_MINUS_IMM, 8'h00, 8'h00, 8'h01, 8'h00,
         16'h8000);
  endtask
  task automatic t_mul;
    for (int i = 16; i < 22; i++)
      exec(cad_pkg::cad_op_e'(i), 8'h80, 8'hFF, 8'h00, 8'hFC);
    exec(cad_pkg::OP_PRODUCT, 8'h00, 8'h37, 8'h00, 8'h00);
  endtask
  task automatic t_flow;
    exec(cad_pkg::OP_INDIRECT_GOTO, 8'h00, 8'h00, 8'h00, 8'h3F,
         16'h1234);
    // the partner takes the new counter on the edge after completion
    @(negedge clk_i);
    chk_val(pc_seen, 16'h1234);
    exec(cad_pkg::OP_INDIRECT_SUBR, 8'h00, 8'h00, 8'h00, 8'h3F,
         16'hBEEF);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    t_add();
    t_sub();
    t_logic();
    t_word();
    t_mul();
    t_flow();
    stop_test();
  end
  initial
  begin
    #20000;
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
